// ### design/rcs_pkg.sv
// Shared constants and types for the reference clock switchover block.
// Assumes a single 40 MHz system clock and an APB register slave.
package rcs_pkg;

  // Register byte offsets
  localparam logic [11:0] RCS_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] RCS_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RCS_SWCOUNT_OFFSET = 12'h008;

  // Control register layout
  localparam int RCS_CTRL_MODE_LSB = 0;
  localparam int RCS_CTRL_MODE_MSB = 1;

  // Status register layout
  localparam int RCS_STAT_LOSS_PRI = 0;
  localparam int RCS_STAT_LOSS_BAK = 1;
  localparam int RCS_STAT_ACTIVE = 2;
  localparam int RCS_STAT_GATED = 3;
  localparam int RCS_STAT_STATE_LSB = 4;
  localparam int RCS_STAT_STATE_MSB = 5;

  // Clock sense figures
  localparam int RCS_CNT_W = 16;
  localparam logic [RCS_CNT_W:0] RCS_LOSS_PERIODS = 17'h00002;
  localparam logic [RCS_CNT_W-1:0] RCS_CNT_MAX = 16'hFFFF;
  localparam logic [RCS_CNT_W-1:0] RCS_CNT_ZERO = 16'h0000;
  localparam logic [RCS_CNT_W-1:0] RCS_CNT_ONE = 16'h0001;

  // Reset values
  localparam logic RCS_SEL_RESET = 1'b0;
  localparam logic [31:0] RCS_ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    RCS_MODE_AUTO = 2'b00,
    RCS_MODE_OVERRIDE = 2'b01,
    RCS_MODE_MANUAL = 2'b10
  } rcs_mode_t;

  localparam rcs_mode_t RCS_MODE_RESET = RCS_MODE_AUTO;

  typedef enum logic [1:0] {
    RCS_ST_IDLE = 2'b00,
    RCS_ST_GATE = 2'b01,
    RCS_ST_SWITCH = 2'b10
  } rcs_state_t;

  // Sampled edges of one input
  typedef struct packed {
    logic rise;
    logic fall;
  } rcs_edge_t;

endpackage

// ### design/rcs_switchover.sv
// Reference clock switchover controller with APB control and status.
// Assumes both reference clocks and the switch request are asynchronous
// pins, sampled here by clk_sys which must run well above both references.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rcs_switchover
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ref_clock_primary,
  input wire logic ref_clock_backup,
  input wire logic switch_request,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ref_clock_out,
  output logic loss_primary,
  output logic loss_backup,
  output logic active_source
);

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] samp_q_reg;
  rcs_pkg::rcs_edge_t ref_edge [2];
  logic req_level;
  logic req_rise;
  logic req_fall;

  logic [rcs_pkg::RCS_CNT_W-1:0] idle_cnt_reg [2];
  logic [rcs_pkg::RCS_CNT_W-1:0] period_reg [2];
  logic loss_reg [2];
  logic loss_hit [2];

  rcs_pkg::rcs_state_t state_reg;
  rcs_pkg::rcs_mode_t mode_reg;
  logic sel_reg;
  logic gate_open_reg;
  logic ref_out_reg;
  logic [15:0] swcount_reg;
  logic target;
  logic auto_go;
  logic manual_go;

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic apb_do;
  logic addr_ok;
  logic [31:0] rd_word;

  // Two-stage sampling of both references and the request; first stage feeds only the second
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      samp_q_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {switch_request, ref_clock_backup, ref_clock_primary};
      sync2_reg <= sync1_reg;
      samp_q_reg <= sync2_reg;
    end
  end

  assign req_level = sync2_reg[2];
  assign req_rise = sync2_reg[2] & ~samp_q_reg[2];
  assign req_fall = ~sync2_reg[2] & samp_q_reg[2];

  // Per-input clock sense: period measured between rising edges
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sense
      assign ref_edge[gi].rise = sync2_reg[gi] & ~samp_q_reg[gi];
      assign ref_edge[gi].fall = ~sync2_reg[gi] & samp_q_reg[gi];
      // Loss limit tracks the input's own period, so no fixed rate is assumed
      assign loss_hit[gi] = (period_reg[gi] != rcs_pkg::RCS_CNT_ZERO) &&
        ({1'b0, idle_cnt_reg[gi]} >=
        17'({1'b0, period_reg[gi]} * rcs_pkg::RCS_LOSS_PERIODS));

      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          idle_cnt_reg[gi] <= rcs_pkg::RCS_CNT_ZERO;
          period_reg[gi] <= rcs_pkg::RCS_CNT_ZERO;
        end
        else if (ref_edge[gi].rise)
        begin
          period_reg[gi] <= idle_cnt_reg[gi] + rcs_pkg::RCS_CNT_ONE;
          idle_cnt_reg[gi] <= rcs_pkg::RCS_CNT_ZERO;
        end
        else if (idle_cnt_reg[gi] != rcs_pkg::RCS_CNT_MAX)
        begin
          idle_cnt_reg[gi] <= idle_cnt_reg[gi] + rcs_pkg::RCS_CNT_ONE;
        end
      end

      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          loss_reg[gi] <= 1'b0;
        end
        else if (ref_edge[gi].rise)
        begin
          loss_reg[gi] <= 1'b0;
        end
        else if (loss_hit[gi])
        begin
          loss_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  assign target = ~sel_reg;
  // Both stopped: nothing to move to, so stay put
  assign auto_go = (mode_reg != rcs_pkg::RCS_MODE_MANUAL) && loss_reg[sel_reg] &&
    !loss_reg[target] &&
    !((mode_reg == rcs_pkg::RCS_MODE_OVERRIDE) && req_level);
  assign manual_go = (mode_reg != rcs_pkg::RCS_MODE_AUTO) && req_rise;

  // Switch sequencing
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= rcs_pkg::RCS_ST_IDLE;
      sel_reg <= rcs_pkg::RCS_SEL_RESET;
      gate_open_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        rcs_pkg::RCS_ST_IDLE:
        begin
          if (manual_go || auto_go)
          begin
            state_reg <= rcs_pkg::RCS_ST_GATE;
          end
        end
        rcs_pkg::RCS_ST_GATE:
        begin
          // A dead current input gives no edge; its output is already low
          if (ref_edge[sel_reg].fall || loss_reg[sel_reg])
          begin
            gate_open_reg <= 1'b0;
            state_reg <= rcs_pkg::RCS_ST_SWITCH;
          end
        end
        rcs_pkg::RCS_ST_SWITCH:
        begin
          if (ref_edge[target].fall)
          begin
            sel_reg <= target;
            gate_open_reg <= 1'b1;
            state_reg <= rcs_pkg::RCS_ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= rcs_pkg::RCS_ST_IDLE;
        end
      endcase
    end
  end

  // Gated reference; opens only while the new input is low
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ref_out_reg <= 1'b0;
    end
    else
    begin
      ref_out_reg <= gate_open_reg & sync2_reg[sel_reg];
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      swcount_reg <= rcs_pkg::RCS_CNT_ZERO;
    end
    else if ((state_reg == rcs_pkg::RCS_ST_SWITCH) && ref_edge[target].fall)
    begin
      swcount_reg <= swcount_reg + rcs_pkg::RCS_CNT_ONE;
    end
  end

  // APB slave: one wait state, pready from a flop
  assign apb_do = psel & penable & ~pready_reg;
  assign addr_ok = (paddr == rcs_pkg::RCS_CTRL_OFFSET) ||
    (paddr == rcs_pkg::RCS_STATUS_OFFSET) || (paddr == rcs_pkg::RCS_SWCOUNT_OFFSET);

  always_comb
  begin
    rd_word = rcs_pkg::RCS_ZERO_WORD;
    case (paddr)
      rcs_pkg::RCS_CTRL_OFFSET:
      begin
        rd_word[rcs_pkg::RCS_CTRL_MODE_MSB:rcs_pkg::RCS_CTRL_MODE_LSB] = mode_reg;
      end
      rcs_pkg::RCS_STATUS_OFFSET:
      begin
        rd_word[rcs_pkg::RCS_STAT_LOSS_PRI] = loss_reg[0];
        rd_word[rcs_pkg::RCS_STAT_LOSS_BAK] = loss_reg[1];
        rd_word[rcs_pkg::RCS_STAT_ACTIVE] = sel_reg;
        rd_word[rcs_pkg::RCS_STAT_GATED] = ~gate_open_reg;
        rd_word[rcs_pkg::RCS_STAT_STATE_MSB:rcs_pkg::RCS_STAT_STATE_LSB] = state_reg;
      end
      rcs_pkg::RCS_SWCOUNT_OFFSET:
      begin
        rd_word[15:0] = swcount_reg;
      end
      default:
      begin
        rd_word = rcs_pkg::RCS_ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= rcs_pkg::RCS_ZERO_WORD;
    end
    else
    begin
      pready_reg <= apb_do;
      pslverr_reg <= apb_do & ~addr_ok;
      prdata_reg <= (apb_do && !pwrite) ? rd_word : rcs_pkg::RCS_ZERO_WORD;
    end
  end

  // Mode write lands with pready; illegal code 3 is kept out
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      mode_reg <= rcs_pkg::RCS_MODE_RESET;
    end
    else if (psel && penable && pready_reg && pwrite &&
      (paddr == rcs_pkg::RCS_CTRL_OFFSET) &&
      (pwdata[rcs_pkg::RCS_CTRL_MODE_MSB:rcs_pkg::RCS_CTRL_MODE_LSB] != 2'h3))
    begin
      mode_reg <= rcs_pkg::rcs_mode_t'(
        pwdata[rcs_pkg::RCS_CTRL_MODE_MSB:rcs_pkg::RCS_CTRL_MODE_LSB]);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ref_clock_out = ref_out_reg;
  assign loss_primary = loss_reg[0];
  assign loss_backup = loss_reg[1];
  assign active_source = sel_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  loss_primary_a: assert property (loss_hit[0] && !ref_edge[0].rise |=> loss_reg[0])
    else $error("primary loss not flagged");
  loss_clear_a: assert property (ref_edge[1].rise |=> !loss_reg[1])
    else $error("backup loss flag set while toggling");
  auto_start_a: assert property (state_reg == rcs_pkg::RCS_ST_IDLE &&
    mode_reg == rcs_pkg::RCS_MODE_AUTO && loss_reg[sel_reg] && !loss_reg[~sel_reg]
    |=> state_reg == rcs_pkg::RCS_ST_GATE)
    else $error("auto switch not started");
  gate_on_fall_a: assert property (state_reg == rcs_pkg::RCS_ST_GATE &&
    ref_edge[sel_reg].fall |=> !gate_open_reg ##1 !ref_out_reg)
    else $error("output not gated on falling edge");
  mux_on_fall_a: assert property ($changed(sel_reg) |->
    $past(state_reg) == rcs_pkg::RCS_ST_SWITCH && !sync2_reg[sel_reg])
    else $error("select moved outside a falling edge");
  wait_target_a: assert property (state_reg == rcs_pkg::RCS_ST_SWITCH &&
    !ref_edge[~sel_reg].fall |=> state_reg == rcs_pkg::RCS_ST_SWITCH && $stable(sel_reg))
    else $error("switch finished without target edge");
  manual_mode_a: assert property (mode_reg == rcs_pkg::RCS_MODE_MANUAL &&
    state_reg == rcs_pkg::RCS_ST_IDLE && !req_rise |=> state_reg == rcs_pkg::RCS_ST_IDLE)
    else $error("manual mode switched on its own");
  held_block_a: assert property (mode_reg == rcs_pkg::RCS_MODE_OVERRIDE &&
    req_level && !req_rise && state_reg == rcs_pkg::RCS_ST_IDLE
    |=> state_reg == rcs_pkg::RCS_ST_IDLE)
    else $error("switch while request held");
  req_fall_a: assert property (req_fall && state_reg == rcs_pkg::RCS_ST_IDLE &&
    mode_reg == rcs_pkg::RCS_MODE_MANUAL |=> state_reg == rcs_pkg::RCS_ST_IDLE)
    else $error("request fall caused a switch");
  both_dead_a: assert property (loss_reg[0] && loss_reg[1] && !req_rise &&
    state_reg == rcs_pkg::RCS_ST_IDLE |=> state_reg == rcs_pkg::RCS_ST_IDLE)
    else $error("switch started with both inputs dead");
  manual_start_a: assert property (mode_reg != rcs_pkg::RCS_MODE_AUTO && req_rise &&
    state_reg == rcs_pkg::RCS_ST_IDLE |=> state_reg == rcs_pkg::RCS_ST_GATE)
    else $error("request rise ignored");
  apb_ready_a: assert property (psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one cycle");

  auto_switch_c: cover property (state_reg == rcs_pkg::RCS_ST_IDLE && auto_go
    ##[1:200] $changed(sel_reg));
  manual_switch_c: cover property (manual_go ##[1:200] $changed(sel_reg));
  both_dead_c: cover property (loss_reg[0] && loss_reg[1]);
  apb_error_c: cover property (pslverr_reg);

endmodule

// ### verif/rcs_req_model.sv
// Far-side model: both reference clocks and the switch requester.
// Assumes clk_sys at 40 MHz; clock edges are built from clk_sys counts.
`timescale 1ns/1ps
module rcs_req_model
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run_pri,
  input wire logic run_bak,
  input wire logic [7:0] half_bak,
  input wire logic go,
  input wire logic hold,
  output logic ref_clock_primary,
  output logic ref_clock_backup,
  output logic switch_request
);
  localparam logic [7:0] HALF_PRI = 8'h0A;
  logic [7:0] cnt_pri;
  logic [7:0] cnt_bak;
  logic [11:0] req_cnt;
  // Stopped clocks rest low, the level the gate step takes a dead input to hold
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt_pri <= 8'h00;
      ref_clock_primary <= 1'b0;
    end
    else if (!run_pri)
      ref_clock_primary <= 1'b0;
    else if (cnt_pri >= HALF_PRI - 8'h01)
    begin
      cnt_pri <= 8'h00;
      ref_clock_primary <= ~ref_clock_primary;
    end
    else
      cnt_pri <= cnt_pri + 8'h01;
  end
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt_bak <= 8'h00;
      ref_clock_backup <= 1'b0;
    end
    else if (!run_bak)
      ref_clock_backup <= 1'b0;
    else if (cnt_bak >= half_bak - 8'h01)
    begin
      cnt_bak <= 8'h00;
      ref_clock_backup <= ~ref_clock_backup;
    end
    else
      cnt_bak <= cnt_bak + 8'h01;
  end
  // High for eight slow periods, past the three needed; then low again
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      req_cnt <= 12'h000;
      switch_request <= 1'b0;
    end
    else if (go)
    begin
      req_cnt <= 12'h000;
      switch_request <= 1'b1;
    end
    else if (switch_request && !hold)
    begin
      req_cnt <= req_cnt + 12'h001;
      if (req_cnt == {half_bak, 4'h0})
        switch_request <= 1'b0;
    end
  end
endmodule

// ### verif/tb.sv
// Self-checking bench for the reference clock switchover block.
// Assumes rcs_req_model drives clocks and requests; APB master is here.
`timescale 1ns/1ps
module tb;
  logic clk_sys, reset, run_pri, run_bak, go, hold, prev, err;
  logic ref_clock_primary, ref_clock_backup, switch_request;
  logic psel, penable, pwrite, pready, pslverr, ref_clock_out;
  logic loss_primary, loss_backup, active_source;
  logic [7:0] half_bak;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [3:0] mon;
  logic [1:0] mode_exp;
  int err_total, checks, cyc, edges;
  assign mon = {switch_request, loss_backup, loss_primary, active_source};
  rcs_switchover dut (.clk_sys(clk_sys), .reset(reset), .ref_clock_primary(ref_clock_primary),
    .ref_clock_backup(ref_clock_backup), .switch_request(switch_request), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clock_out(ref_clock_out),
    .loss_primary(loss_primary), .loss_backup(loss_backup), .active_source(active_source));
  rcs_req_model peer (.clk_sys(clk_sys), .reset(reset), .run_pri(run_pri), .run_bak(run_bak),
    .half_bak(half_bak), .go(go), .hold(hold), .ref_clock_primary(ref_clock_primary),
    .ref_clock_backup(ref_clock_backup), .switch_request(switch_request));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Mode 3 is refused, so the old mode stays
  function automatic logic [1:0] next_mode(input logic [1:0] old, input logic [1:0] w);
    return (w == 2'h3) ? old : w;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for pready however long it takes; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic mode(input logic [1:0] m);
    apb(1'b1, rcs_pkg::RCS_CTRL_OFFSET, {30'h0, m});
  endtask
  task automatic wait_bit(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (mon[i] !== v && k < n)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk(mon[i], v);
  endtask
  task automatic pulse;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Ceiling well above the roughly 3000 cycles the sequence needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    {reset, run_pri, run_bak} = 3'h7;
    {go, hold, psel, penable, pwrite} = 5'h00;
    half_bak = 8'h0B;
    paddr = 12'h000;
    pwdata = 32'h0;
    rnd = 32'h61;
    mode_exp = 2'h0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({ref_clock_out, loss_primary, loss_backup, active_source}, 32'h0);
    apb(1'b0, rcs_pkg::RCS_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, rcs_pkg::RCS_SWCOUNT_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    for (int j = 0; j < 6; j++)
    begin
      rnd = xs(rnd);
      mode_exp = next_mode(mode_exp, (j == 5) ? 2'h3 : rnd[1:0]);
      apb(1'b1, rcs_pkg::RCS_CTRL_OFFSET, (j == 5) ? 32'h3 : rnd);
      apb(1'b0, rcs_pkg::RCS_CTRL_OFFSET, 32'h0);
      chk(rd, {30'h0, mode_exp});
    end
    mode(2'h0);
    pulse();
    repeat (400) @(posedge clk_sys);
    chk(active_source, 1'b0);
    run_pri <= 1'b0;
    wait_bit(1, 1'b1, 300);
    wait_bit(0, 1'b1, 300);
    chk(loss_backup, 1'b0);
    edges = 0;
    prev = ref_clock_out;
    repeat (200)
    begin
      @(posedge clk_sys);
      edges += int'(ref_clock_out !== prev);
      prev = ref_clock_out;
    end
    chk(edges > 10, 1'b1);
    run_pri <= 1'b1;
    wait_bit(1, 1'b0, 100);
    mode(2'h2);
    pulse();
    wait_bit(0, 1'b0, 300);
    chk(mon[2:1], 2'h0);
    wait_bit(3, 1'b0, 1000);
    repeat (100) @(posedge clk_sys);
    chk(active_source, 1'b0);
    run_pri <= 1'b0;
    wait_bit(1, 1'b1, 300);
    repeat (200) @(posedge clk_sys);
    chk(active_source, 1'b0);
    run_pri <= 1'b1;
    wait_bit(1, 1'b0, 100);
    run_bak <= 1'b0;
    pulse();
    repeat (300) @(posedge clk_sys);
    chk(active_source, 1'b0);
    run_bak <= 1'b1;
    wait_bit(0, 1'b1, 300);
    wait_bit(3, 1'b0, 1000);
    pulse();
    wait_bit(0, 1'b0, 300);
    wait_bit(3, 1'b0, 1000);
    mode(2'h1);
    hold <= 1'b1;
    pulse();
    wait_bit(0, 1'b1, 300);
    chk(active_source, switch_request);
    run_bak <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk(active_source, 1'b1);
    run_bak <= 1'b1;
    hold <= 1'b0;
    wait_bit(3, 1'b0, 1000);
    half_bak <= 8'h1E;
    pulse();
    wait_bit(0, 1'b0, 600);
    wait_bit(3, 1'b0, 1500);
    apb(1'b0, rcs_pkg::RCS_SWCOUNT_OFFSET, 32'h0);
    chk(rd, 32'h6);
    // Backup dies first, so the later primary loss finds nothing to move to
    mode(2'h0);
    run_bak <= 1'b0;
    wait_bit(2, 1'b1, 300);
    run_pri <= 1'b0;
    wait_bit(1, 1'b1, 300);
    repeat (100) @(posedge clk_sys);
    chk(active_source, 1'b0);
    apb(1'b0, rcs_pkg::RCS_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h3);
    tally_and_finish();
  end
endmodule
